// [sac_top.sv]
// module: conversion sequencer and result register of the converter
`timescale 1ns/1ps
module sac_top
  import sac_pkg::*;
(
  input wire clk,
  input wire rst,
  input wire conversion_start_n,
  input wire conv_clk,
  input wire chip_sel_n,
  input wire read_n,
  input wire half_sel,
  input wire [15:0] sar_code,
  output logic busy,
  output logic sample_hold,
  output logic [15:0] result_output_bus,
  output logic result_bus_oe
);
  //--------------------------------------------------------------
  // register state
  //--------------------------------------------------------------
  // every register of this module lives in one struct: the pin
  // synchronisers, the edge detectors and the sequencer; one
  // always_comb works out the next copy and one always_ff keeps it
  typedef struct packed {
    logic [4:0] sync1; // first stage, read only by the second stage
    logic [4:0] sync2; // second stage, the copy that logic may read
    sac_state_t st; // sequencer state
    logic start_prev; // start strobe one cycle ago
    logic cclk_prev; // conversion clock one cycle ago
    logic [SAC_CNT_W-1:0] edges; // conversion clock rises seen so far
    logic busy; // conversion in progress
    logic hold; // sampler held
    logic [15:0] result; // output register
  } sac_seq_t;
  sac_seq_t s_q, s_d;

  // count of the sixteenth rise, the last one before the latch
  localparam logic [SAC_CNT_W-1:0] LAST_EDGE = SAC_LATCH_EDGE - 5'h01;

  //--------------------------------------------------------------
  // input synchronisers
  //--------------------------------------------------------------
  // pins are asynchronous to clk; bit order is start strobe,
  // conversion clock, chip select, read strobe, half select
  logic [4:0] pins;
  assign pins = {conversion_start_n, conv_clk, chip_sel_n, read_n, half_sel};

  // named copies of the second stage; two flops cost two cycles of
  // latency on every pin, traded for freedom from metastability
  logic start_n_s, cclk_s, cs_n_s, rd_n_s, half_s;
  assign start_n_s = s_q.sync2[4];
  assign cclk_s = s_q.sync2[3];
  assign cs_n_s = s_q.sync2[2];
  assign rd_n_s = s_q.sync2[1];
  assign half_s = s_q.sync2[0];

  //--------------------------------------------------------------
  // edge detection
  //--------------------------------------------------------------
  // the previous values reset high like the synchronisers, so a
  // strobe idling high shows no fall and a clock parked low shows
  // only a fall after reset, never a false rise
  logic start_fall, cclk_rise, start_req, latch_now;
  assign start_fall = s_q.start_prev && !start_n_s;
  assign cclk_rise = !s_q.cclk_prev && cclk_s;
  // a strobe fall requests a conversion only with chip select low
  assign start_req = start_fall && !cs_n_s;
  // the seventeenth counted rise latches the result
  assign latch_now = (s_q.st == SAC_CONV) && cclk_rise
    && (s_q.edges == LAST_EDGE);

  //--------------------------------------------------------------
  // conversion sequencer
  //--------------------------------------------------------------
  // idle until a start request, wait for the first conversion clock
  // rise, then count rises until the seventeenth latches the result
  always_comb begin
    s_d = s_q;
    // synchroniser stages and edge detector history shift every cycle
    s_d.sync1 = pins;
    s_d.sync2 = s_q.sync1;
    s_d.start_prev = start_n_s;
    s_d.cclk_prev = cclk_s;
    unique case (s_q.st)
      SAC_IDLE: begin
        if (start_req) begin
          s_d.st = SAC_WAIT;
          s_d.hold = 1'b1;
          s_d.busy = 1'b1;
          s_d.edges = '0;
        end
      end
      SAC_WAIT: begin
        // further strobe falls are simply not looked at here
        if (cclk_rise) begin
          s_d.st = SAC_CONV;
          s_d.edges = 5'h01; // rise one
        end
      end
      SAC_CONV: begin
        // strobe falls are not looked at during conversion either
        if (cclk_rise) begin
          s_d.edges = s_q.edges + 5'h01;
        end
        if (latch_now) begin
          // the core hands its code over in two's complement
          s_d.result = sar_code;
          s_d.busy = 1'b0;
          s_d.hold = 1'b0; // sampler tracks again
          s_d.st = SAC_IDLE;
        end
      end
    endcase
  end

  // synchronous reset; a reset in mid-conversion abandons it and
  // clears the result, since a half-counted code is worthless
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.sync1 <= '1;
      s_q.sync2 <= '1;
      s_q.st <= SAC_IDLE;
      s_q.start_prev <= 1'b1;
      s_q.cclk_prev <= 1'b1;
      s_q.edges <= '0;
      s_q.busy <= 1'b0;
      s_q.hold <= 1'b0;
      s_q.result <= SAC_RESULT_RST;
    end else begin
      s_q <= s_d;
    end
  end
  // outputs straight from the state flops
  assign busy = s_q.busy;
  assign sample_hold = s_q.hold;

  //--------------------------------------------------------------
  // read path
  //--------------------------------------------------------------
  // the bus sees the result register, the combined read enable and
  // the retimed half select; its outputs are one flop behind these
  sac_rd_if rif ();
  assign rif.result = s_q.result;
  assign rif.rd_en = !cs_n_s && !rd_n_s;
  assign rif.half_sel = half_s;

  sac_rdbus u_bus (
    .clk(clk),
    .rst(rst),
    .rif(rif),
    .bus_d(result_output_bus),
    .bus_oe(result_bus_oe)
  );

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  // a start request seen while idle
  sequence s_start;
    (s_q.st == SAC_IDLE) && start_req;
  endsequence
  // the first conversion clock rise while waiting
  sequence s_first_rise;
    (s_q.st == SAC_WAIT) && cclk_rise;
  endsequence
  // the rise that latches the result
  sequence s_latch;
    latch_now;
  endsequence

  // start and busy
  a_busy_on_start: assert property (
    @(posedge clk) disable iff (rst) s_start |=> busy && sample_hold)
    else $error("busy late");
  a_busy_held: assert property (
    @(posedge clk) disable iff (rst) (s_q.st != SAC_IDLE) |-> busy)
    else $error("busy dropped");
  // counting and latching
  a_first_rise: assert property (
    @(posedge clk) disable iff (rst)
    s_first_rise |=> (s_q.st == SAC_CONV) && (s_q.edges == 5'h01))
    else $error("first conversion rise not counted");
  a_latch_busy_low: assert property (
    @(posedge clk) disable iff (rst)
    s_latch |=> !busy && (s_q.result == $past(sar_code)))
    else $error("latch at rise seventeen wrong");
  a_result_kept: assert property (
    @(posedge clk) disable iff (rst) !latch_now |=> $stable(s_q.result))
    else $error("result register changed outside latch");
  a_edge_count: assert property (
    @(posedge clk) disable iff (rst)
    $fell(busy) |-> ($past(s_q.edges) == LAST_EDGE))
    else $error("wrong edge count");
  // refused strobes
  a_ignore_restart: assert property (
    @(posedge clk) disable iff (rst)
    (s_q.st == SAC_CONV) && !cclk_rise |=> (s_q.st == SAC_CONV))
    else $error("restart not ignored");
  a_wait_ignore: assert property (
    @(posedge clk) disable iff (rst)
    (s_q.st == SAC_WAIT) && !cclk_rise |=> (s_q.st == SAC_WAIT) && busy)
    else $error("restart not ignored while waiting");
  a_refuse_no_cs: assert property (
    @(posedge clk) disable iff (rst)
    (s_q.st == SAC_IDLE) && start_fall && cs_n_s |=> !busy)
    else $error("start taken with chip select high");
  a_idle_low: assert property (
    @(posedge clk) disable iff (rst)
    (s_q.st == SAC_IDLE) && !start_req |=> !busy)
    else $error("busy while idle");
endmodule

// [sac_pkg.sv]
// package: constants and types for the converter control block
package sac_pkg;
  localparam int SAC_RES_W = 16;
  localparam int SAC_CONV_EDGES = 16;
  localparam int SAC_CNT_W = 5;
  localparam logic [SAC_CNT_W-1:0] SAC_LATCH_EDGE = 5'h11;
  localparam logic [15:0] SAC_RESULT_RST = 16'h0000;
  localparam int SAC_MIN_CLK_KHZ = 25;
  localparam int SAC_MAX_CLK_KHZ = 10000;
  localparam int SAC_CONVERSION_START_N_LOW_NS = 20;
  localparam int SAC_SYS_PERIOD_NS = 10;
  localparam int SAC_CONVERSION_START_N_LOW_CYC =
    (SAC_CONVERSION_START_N_LOW_NS + SAC_SYS_PERIOD_NS - 1) / SAC_SYS_PERIOD_NS;
  typedef enum logic [1:0] {SAC_IDLE, SAC_WAIT, SAC_CONV} sac_state_t;
endpackage

// [sac_rd_if.sv]
// interface: result word and read-side controls between sequencer and bus
`timescale 1ns/1ps
interface sac_rd_if;
  logic [15:0] result;
  logic rd_en;
  logic half_sel;
  modport seq (output result, output rd_en, output half_sel);
  modport bus (input result, input rd_en, input half_sel);
endinterface

// [sac_rdbus.sv]
// module: parallel output bus driver with half-word select
`timescale 1ns/1ps
module sac_rdbus
  import sac_pkg::*;
(
  input wire clk,
  input wire rst,
  sac_rd_if.bus rif,
  output logic [15:0] bus_d,
  output logic bus_oe
);
  typedef struct packed {
    logic [15:0] data;
    logic oe;
  } sac_bus_st_t;
  sac_bus_st_t s_q, s_d;

  // choose word or upper byte; the select is only retimed, never clocked gated
  always_comb begin
    s_d.oe = rif.rd_en;
    if (rif.half_sel) begin
      s_d.data = {8'h00, rif.result[15:8]};
    end else begin
      s_d.data = rif.result;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign bus_d = s_q.data;
  assign bus_oe = s_q.oe;

  a_bus_oe_follow: assert property (
    @(posedge clk) disable iff (rst) rif.rd_en |=> bus_oe)
    else $error("bus not enabled on read");
  a_bus_float_idle: assert property (
    @(posedge clk) disable iff (rst) !rif.rd_en |=> !bus_oe)
    else $error("bus driven when idle");
  a_bus_hi_byte: assert property (
    @(posedge clk) disable iff (rst)
    rif.half_sel |=> bus_d == {8'h00, $past(rif.result[15:8])})
    else $error("upper byte not on low lines");
  a_bus_full_word: assert property (
    @(posedge clk) disable iff (rst)
    !rif.half_sel |=> bus_d == $past(rif.result))
    else $error("full word wrong");
endmodule

// [sac_host_model.sv]
// host side model: start strobe, conversion clock and read controls
`timescale 1ns/1ps
module sac_host_model (
  input wire clk,
  output logic conversion_start_n,
  output logic conv_clk,
  output logic chip_sel_n,
  output logic read_n,
  output logic half_sel
);
  // ----------------------------------------
  // idle levels: strobes high, clock parked
  // ----------------------------------------
  initial begin
    conversion_start_n = 1'b1;
    conv_clk = 1'b0;
    chip_sel_n = 1'b1;
    read_n = 1'b1;
    half_sel = 1'b0;
  end
  // strobe low three cycles, 30 ns, above the 20 ns floor
  task pulse_start(input logic cs_n);
    @(posedge clk);
    #1;
    chip_sel_n = cs_n;
    conversion_start_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    conversion_start_n = 1'b1;
    chip_sel_n = 1'b1;
  endtask
  // one 100 ns period, 10 MHz, so the clock stays still between rises
  task clk_rise();
    @(posedge clk);
    #1;
    conv_clk = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    conv_clk = 1'b0;
    repeat (4) @(posedge clk);
    // leave just after the edge so callers sample settled outputs
    #1;
  endtask
  // read controls; half select may move while read stays low
  task set_rd(input logic cs_n, input logic rd_n, input logic hs);
    @(posedge clk);
    #1;
    chip_sel_n = cs_n;
    read_n = rd_n;
    half_sel = hs;
  endtask
endmodule

// [tb_top.sv]
// testbench: conversions, ignored strobes and word and byte reads
`timescale 1ns/1ps
module tb_top;
  import sac_pkg::*;
  logic clk, rst, cs_n, rd_n, hs, st_n, cclk, busy, hold, oe;
  logic [15:0] code, bus, sar;
  int errors, compares;
  sac_host_model i_sac_host_model (.clk(clk), .conversion_start_n(st_n),
    .conv_clk(cclk), .chip_sel_n(cs_n), .read_n(rd_n), .half_sel(hs));
  sac_top i_sac_top (.clk(clk), .rst(rst), .conversion_start_n(st_n),
    .conv_clk(cclk), .chip_sel_n(cs_n), .read_n(rd_n), .half_sel(hs),
    .sar_code(sar), .busy(busy), .sample_hold(hold),
    .result_output_bus(bus), .result_bus_oe(oe));
  // -------------------------
  // clock, watchdog, checking
  // -------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200us;
    errors++;
    stop_test();
  end
  // byte mode puts the upper half on the low lines, zeros above
  function automatic logic [15:0] exp_bus(logic [15:0] c, logic h);
    return h ? {8'h00, c[15:8]} : c;
  endfunction
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task stop_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // -------------------------
  // main sequence
  // -------------------------
  initial begin
    rst = 1'b1;
    sar = 16'h0000;
    void'($urandom(32'h8d1e));
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("busy idle", 16'h0000, {15'h0, busy});
    // strobe with chip select high must not start anything
    i_sac_host_model.pulse_start(1'b1);
    repeat (6) @(posedge clk);
    #1;
    chk("busy no cs", 16'h0000, {15'h0, busy});
    for (int n = 0; n < 5; n++) begin
      // extremes of the two's complement range first, then random
      code = (n == 0) ? 16'h8000 : (n == 1) ? 16'h7FFF : 16'($urandom);
      sar = code;
      i_sac_host_model.pulse_start(1'b0);
      repeat (2) @(posedge clk);
      #1;
      chk("busy start", 16'h0001, {15'h0, busy});
      chk("hold", 16'h0001, {15'h0, hold});
      for (int i = 1; i <= 17; i++) begin
        if (i == 5) i_sac_host_model.pulse_start(1'b0);
        i_sac_host_model.clk_rise();
        if (i == 16) chk("busy 16", 16'h0001, {15'h0, busy});
      end
      chk("busy end", 16'h0000, {15'h0, busy});
      chk("hold end", 16'h0000, {15'h0, hold});
      sar = ~code; // result register must not follow the core later
      i_sac_host_model.set_rd(1'b0, 1'b0, 1'b0);
      repeat (4) @(posedge clk);
      #1;
      chk("word", exp_bus(code, 1'b0), bus);
      chk("oe on", 16'h0001, {15'h0, oe});
      i_sac_host_model.set_rd(1'b0, 1'b0, 1'b1);
      repeat (4) @(posedge clk);
      #1;
      chk("byte", exp_bus(code, 1'b1), bus);
      i_sac_host_model.set_rd(1'b1, 1'b0, 1'b0);
      repeat (4) @(posedge clk);
      #1;
      chk("oe cs high", 16'h0000, {15'h0, oe});
      i_sac_host_model.set_rd(1'b0, 1'b1, 1'b0);
      repeat (4) @(posedge clk);
      #1;
      chk("oe rd high", 16'h0000, {15'h0, oe});
      i_sac_host_model.set_rd(1'b1, 1'b1, 1'b0);
    end
    stop_test();
  end
endmodule
